// ==== tifs_segmenter.sv ====
/*
 * Interval interleaver with radio frame segmentation: collects one
 * block of bits, permutes the matrix columns, reads out column by
 * column and marks each per-frame segment start.
 * Assumes upstream keeps the block length a multiple of the frame
 * count and an APB master programs the length and interval.
 * Assumes lengths of at most 4096 bits; software must not start a
 * block longer than the matrix, as the fill would then close after
 * only the length modulo 4096 bits.
 */
`timescale 1ns/1ps
module tifs_segmenter (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bit input stream
    input  wire logic        in_valid,
    input  wire logic        in_bit,
    output logic             in_ready,
    // Bit output stream
    input  wire logic        out_ready,
    output logic             out_valid,
    output logic             out_bit,
    output logic             out_seg_start,
    output logic       [2:0] out_frame,
    output logic             out_last
);
    // Configuration registers
    logic [1:0]  tti_ff;                 // Interval code
    logic [1:0]  mode_ff;                // Link mode, informative
    logic        en_ff;                  // Stream enable
    logic [15:0] len_ff;                 // Block length in bits
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    // Datapath state
    tifs_pkg::tifs_state_t state_ff;     // Current sequencer state
    tifs_pkg::tifs_state_t nxt_state;    // Next sequencer state
    logic [tifs_pkg::AW-1:0] wcnt_ff;    // Write index
    logic [2:0]   col_ff;                // Column counter, before permutation
    logic [tifs_pkg::AW-1:0] row_ff;     // Row within column
    logic [tifs_pkg::AW-1:0] seg_ff;     // Bit within segment
    logic [2:0]   frame_ff;              // Frame of interval
    logic         ovalid_ff;
    logic         obit_ff;
    logic         oseg_ff;
    logic [2:0]   oframe_ff;
    logic         olast_ff;
    logic         iready_ff;
    logic [15:0]  blocks_ff;             // Completed blocks
    logic mem [0:tifs_pkg::MAX_BITS-1];  // Interleaver matrix

    // Bus decode
    wire apb_setup  = psel & ~penable;
    wire apb_wr     = psel & penable & pwrite & pready_ff;
    wire hit_ctrl   = paddr == tifs_pkg::CTRL_OFF;
    wire hit_len    = paddr == tifs_pkg::LEN_OFF;
    wire hit_stat   = paddr == tifs_pkg::STAT_OFF;
    wire hit_frame  = paddr == tifs_pkg::FRAME_OFF;
    wire hit_any    = hit_ctrl | hit_len | hit_stat | hit_frame;

    // Geometry: columns and frames share the count
    wire [3:0] ncols = 4'h1 << tti_ff;
    wire [1:0] lg    = tti_ff;
    // A 4096-bit block wraps length, and rows at one column, to zero; the minus-one
    // compares below still close on the right count
    wire [tifs_pkg::AW-1:0] nrows = tifs_pkg::AW'(len_ff >> lg);
    wire [tifs_pkg::AW-1:0] nbits = tifs_pkg::AW'(len_ff);
    // Bit-reversed column over lg bits gives {0},{0,1},{0,2,1,3},{0,4,2,6,...}
    wire [2:0] rev3  = {col_ff[0], col_ff[1], col_ff[2]};
    wire [2:0] pcol  = 3'(rev3 >> (2'h3 - lg));
    // Read address: row-major storage, column-major fetch
    wire [tifs_pkg::AW-1:0] raddr = tifs_pkg::AW'((row_ff << lg) | tifs_pkg::AW'(pcol));
    wire in_take   = (state_ff == tifs_pkg::S_FILL) & in_valid & iready_ff;
    wire out_move  = ~ovalid_ff | out_ready;
    wire rd_fire   = (state_ff == tifs_pkg::S_READ) & out_move;
    wire last_row  = row_ff == nrows - 1'b1;
    wire last_col  = col_ff == 3'(ncols - 4'h1);
    wire last_seg  = seg_ff == nrows - 1'b1;
    wire fill_done = in_take & (wcnt_ff == nbits - 1'b1);
    wire read_done = rd_fire & last_row & last_col;

    // Next state of the stream sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // Length zero never starts a block
            tifs_pkg::S_IDLE: if (en_ff && len_ff != 16'h0000) nxt_state = tifs_pkg::S_FILL;
            tifs_pkg::S_FILL: if (fill_done) nxt_state = tifs_pkg::S_READ;
            tifs_pkg::S_READ: if (read_done) nxt_state = tifs_pkg::S_IDLE;
            default:          nxt_state = tifs_pkg::S_IDLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= tifs_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Matrix write, row by row in arrival order
    always_ff @(posedge pclk) begin
        if (in_take) begin
            mem[wcnt_ff] <= in_bit;
        end
    end

    // Write index and input ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wcnt_ff   <= '0;
            iready_ff <= 1'b0;
        end else begin
            // Ready drops on the edge that stores the last bit
            iready_ff <= (nxt_state == tifs_pkg::S_FILL) & ~fill_done;
            if (fill_done || state_ff == tifs_pkg::S_IDLE) begin
                wcnt_ff <= '0;
            end else if (in_take) begin
                wcnt_ff <= wcnt_ff + 1'b1;
            end
        end
    end

    // Read walk: rows inside a permuted column
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_ff <= '0;
            col_ff <= 3'h0;
        end else if (state_ff != tifs_pkg::S_READ) begin
            // Walk restarts at row 0, column 0 for each block
            row_ff <= '0;
            col_ff <= 3'h0;
        end else if (rd_fire) begin
            if (last_row) begin
                row_ff <= '0;
                col_ff <= col_ff + 3'h1;
            end else begin
                row_ff <= row_ff + 1'b1;
            end
        end
    end

    // Segment and frame counters over the output order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_ff   <= '0;
            frame_ff <= 3'h0;
        end else if (state_ff != tifs_pkg::S_READ) begin
            seg_ff   <= '0;
            frame_ff <= 3'h0;
        end else if (rd_fire) begin
            if (last_seg) begin
                seg_ff   <= '0;
                frame_ff <= frame_ff + 3'h1;
            end else begin
                seg_ff <= seg_ff + 1'b1;
            end
        end
    end

    // Output register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovalid_ff <= 1'b0;
            obit_ff   <= 1'b0;
            oseg_ff   <= 1'b0;
            oframe_ff <= 3'h0;
            olast_ff  <= 1'b0;
        end else if (out_move) begin
            ovalid_ff <= rd_fire;
            obit_ff   <= rd_fire & mem[raddr];
            oseg_ff   <= rd_fire & (seg_ff == '0);
            oframe_ff <= frame_ff;
            olast_ff  <= read_done;
        end
    end

    // Completed block counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blocks_ff <= 16'h0000;
        end else if (read_done) begin
            blocks_ff <= blocks_ff + 16'h0001;
        end
    end

    // Register writes; length, interval and mode refused while a block is in flight, enable always taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tti_ff  <= tifs_pkg::TTI_RST;
            mode_ff <= tifs_pkg::MODE_RST;
            en_ff   <= 1'b0;
            len_ff  <= tifs_pkg::LEN_RST;
        end else if (apb_wr && hit_ctrl) begin
            en_ff <= pwdata[tifs_pkg::CTRL_EN_BIT];
            // Geometry frozen while a block is in flight
            if (state_ff == tifs_pkg::S_IDLE) begin
                tti_ff  <= pwdata[tifs_pkg::CTRL_TTI_LSB +: 2];
                mode_ff <= pwdata[tifs_pkg::CTRL_MODE_LSB +: 2];
            end
        end else if (apb_wr && hit_len && state_ff == tifs_pkg::S_IDLE) begin
            len_ff <= pwdata[15:0];
        end
    end

    // Read mux
    wire [31:0] rd_mux =
        hit_ctrl  ? {27'h0, en_ff, mode_ff, tti_ff} :
        hit_len   ? {16'h0, len_ff} :
        hit_stat  ? {16'h0, blocks_ff[12:0], state_ff} :
        hit_frame ? {29'h0, frame_ff} : 32'h0;

    // APB answer: no wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup & ~hit_any;
            if (apb_setup) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign in_ready  = iready_ff;
    assign out_valid = ovalid_ff;
    assign out_bit   = obit_ff;
    assign out_seg_start = oseg_ff;
    assign out_frame = oframe_ff;
    assign out_last  = olast_ff;

    // Checks, all on pclk and idle in reset
    // Column walk stays inside the selected column count
    property p_cols;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == tifs_pkg::S_READ) |-> {1'b0, col_ff} < ncols;
    endproperty
    a_cols: assert property (p_cols) else $error("column index beyond count");

    // Row walk stays inside the row count
    property p_rows;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == tifs_pkg::S_READ) |-> row_ff <= nrows - 1'b1;
    endproperty
    a_rows: assert property (p_rows) else $error("row index beyond count");

    // Second permuted column of the four-column pattern
    property p_pcol40;
        @(posedge pclk) disable iff (!presetn)
        (tti_ff == tifs_pkg::TTI_40 && col_ff == 3'h1) |-> pcol == 3'h2;
    endproperty
    a_pcol40: assert property (p_pcol40) else $error("40 ms pattern wrong");

    // Fourth permuted column of the eight-column pattern
    property p_pcol80;
        @(posedge pclk) disable iff (!presetn)
        (tti_ff == tifs_pkg::TTI_80 && col_ff == 3'h3) |-> pcol == 3'h6;
    endproperty
    a_pcol80: assert property (p_pcol80) else $error("80 ms pattern wrong");

    // Input is closed while the matrix is read
    property p_noready_read;
        @(posedge pclk) disable iff (!presetn) (state_ff == tifs_pkg::S_READ) |-> !in_ready;
    endproperty
    a_noready_read: assert property (p_noready_read) else $error("input taken during readout");

    // Input is open only while the matrix fills
    property p_in_fill;
        @(posedge pclk) disable iff (!presetn) in_ready |-> state_ff == tifs_pkg::S_FILL;
    endproperty
    a_in_fill: assert property (p_in_fill) else $error("input open outside fill");

    // A taken segment start is followed by a plain bit
    property p_segfirst;
        @(posedge pclk) disable iff (!presetn)
        (out_valid && out_ready && out_seg_start && nrows != 12'h001) |=> !out_seg_start;
    endproperty
    a_segfirst: assert property (p_segfirst) else $error("segment mark repeated");

    // Stalled output holds its bit and marks
    property p_out_hold;
        @(posedge pclk) disable iff (!presetn)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_bit) && $stable(out_frame)
            && $stable(out_seg_start) && $stable(out_last));
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("stalled output changed");

    // Frame index stays below the frame count
    property p_frame_range;
        @(posedge pclk) disable iff (!presetn) out_valid |-> {1'b0, out_frame} < ncols;
    endproperty
    a_frame_range: assert property (p_frame_range) else $error("frame index out of range");

    // Final bit belongs to the final frame
    property p_last_frame;
        @(posedge pclk) disable iff (!presetn) (out_valid && out_last) |-> out_frame == 3'(ncols - 4'h1);
    endproperty
    a_last_frame: assert property (p_last_frame) else $error("last bit not in final frame");

    // Readout ends on the last bit of the last column
    property p_read_to_idle;
        @(posedge pclk) disable iff (!presetn) read_done |=> state_ff == tifs_pkg::S_IDLE;
    endproperty
    a_read_to_idle: assert property (p_read_to_idle) else $error("readout did not end");

    // Fill ends on the programmed length
    property p_fill_to_read;
        @(posedge pclk) disable iff (!presetn) fill_done |=> (state_ff == tifs_pkg::S_READ && wcnt_ff == '0);
    endproperty
    a_fill_to_read: assert property (p_fill_to_read) else $error("fill did not end on length");
endmodule

// ==== tifs_pkg.sv ====
/*
 * Constants for the interval interleaver and frame segmenter.
 * Assumes a single pclk domain; used by the segmenter top and the bench.
 */
package tifs_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [11:0] CTRL_OFF   = 12'h000;
    localparam logic [11:0] LEN_OFF    = 12'h004;
    localparam logic [11:0] STAT_OFF   = 12'h008;
    localparam logic [11:0] FRAME_OFF  = 12'h00C;
    // Control fields
    localparam int CTRL_TTI_LSB  = 0;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_EN_BIT   = 4;
    // Reset values
    localparam logic [1:0]  TTI_RST  = 2'h0;
    localparam logic [1:0]  MODE_RST = 2'h0;
    localparam logic [15:0] LEN_RST  = 16'h0000;
    // Interval codes
    localparam logic [1:0] TTI_10 = 2'h0;
    localparam logic [1:0] TTI_20 = 2'h1;
    localparam logic [1:0] TTI_40 = 2'h2;
    localparam logic [1:0] TTI_80 = 2'h3;
    // Link modes: uplink, downlink fixed, downlink flexible
    localparam logic [1:0] MODE_UL    = 2'h0;
    localparam logic [1:0] MODE_DLFIX = 2'h1;
    localparam logic [1:0] MODE_DLFLX = 2'h2;
    // Matrix capacity in bits
    localparam int MAX_BITS = 4096;
    localparam int AW       = 12;
    // Streaming states
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_FILL = 3'b010,
        S_READ = 3'b100
    } tifs_state_t;
endpackage

// ==== tifs_partner.sv ====
/* Upstream bit source and downstream bit sink for the segmenter.
   Assumes the bench drives go, nbits, hold and slow after pclk edges. */
`timescale 1ns/1ps
module tifs_partner (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench control
    input  wire logic        go,
    input  wire logic [15:0] nbits,
    input  wire logic        hold,
    input  wire logic        slow,
    // Stream handshakes
    input  wire logic        in_ready,
    output logic             in_valid,
    output logic             in_bit,
    output logic             out_ready
);
    logic [15:0] cnt_ff; // Bits handed over
    logic        tog_ff; // Slow sink phase
    // Test pattern of one input index
    function automatic logic pat(input int i);
        return ^((i * 32'hB + 32'h3) & 32'hD6);
    endfunction
    // Whole block of nbits, a multiple of the frame count
    assign in_valid  = go && (cnt_ff < nbits);
    // Idle data line shows the inverse, never stale data
    assign in_bit    = in_valid ? pat(32'(cnt_ff)) : ~pat(32'(cnt_ff));
    // Sink stalls while held, every other cycle when slow
    assign out_ready = !hold && (!slow || tog_ff);
    // Count accepted bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0000;
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
            if (!go) begin
                cnt_ff <= 16'h0000;
            end else if (in_valid && in_ready) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
endmodule

// ==== tb_tifs_segmenter.sv ====
/* Self-checking bench: APB programming, block streaming, output order.
   Assumes the segmenter, its package and the partner model are compiled first. */
`timescale 1ns/1ps
module tb_tifs_segmenter;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        in_valid, in_bit, in_ready, out_ready, out_valid, out_bit;
    logic        out_seg_start, out_last, go, hold, slow, err;
    logic [2:0]  out_frame;
    logic [15:0] nbits;
    int          fails, total_checks, ocnt, cur_len, cur_tti;
    // Clock
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;
    tifs_segmenter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_bit(in_bit), .in_ready(in_ready),
        .out_ready(out_ready), .out_valid(out_valid), .out_bit(out_bit),
        .out_seg_start(out_seg_start), .out_frame(out_frame), .out_last(out_last));
    tifs_partner i_prt (.pclk(pclk), .presetn(presetn), .go(go), .nbits(nbits), .hold(hold),
        .slow(slow), .in_ready(in_ready), .in_valid(in_valid), .in_bit(in_bit),
        .out_ready(out_ready));
    // Own copy of the source pattern
    function automatic logic pat(input int i);
        return ^((i * 32'hB + 32'h3) & 32'hD6);
    endfunction
    // Bit reversal of a column index over t bits
    function automatic int brev(input int j, input int t);
        int b;
        b = 0;
        for (int q = 0; q < t; q++) b |= ((j >> q) & 1) << (t - 1 - q);
        return b;
    endfunction
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Output monitor: column-major read of the permuted matrix
    always @(posedge pclk) begin
        int rows, j, r;
        if (presetn && out_valid === 1'b1 && out_ready) begin
            rows = cur_len >> cur_tti;
            j = ocnt / rows;
            r = ocnt % rows;
            chk("out_bit", 32'(pat(r * (1 << cur_tti) + brev(j, cur_tti))), 32'(out_bit));
            chk("seg_start", 32'(r == 0), 32'(out_seg_start));
            chk("frame", 32'(j), 32'(out_frame));
            chk("last", 32'(ocnt == cur_len - 1), 32'(out_last));
            ocnt++;
        end
    end
    // Verdict and end of run
    task automatic results;
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #2000000;
        fails++;
        results();
    end
    // One block: program, stream in, stall, release, check counts
    task automatic run(input int b, input int t, input int m, input logic s);
        int n;
        cur_tti = t;
        cur_len = 3 << t;
        ocnt = 0;
        n = 0;
        apb(1'b1, tifs_pkg::LEN_OFF, 32'(cur_len));
        apb(1'b1, tifs_pkg::CTRL_OFF, 32'((1 << tifs_pkg::CTRL_EN_BIT) | (m << tifs_pkg::CTRL_MODE_LSB) | t));
        go    <= 1'b1;
        nbits <= 16'(cur_len);
        slow  <= s;
        while (out_valid !== 1'b1 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        apb(1'b1, tifs_pkg::LEN_OFF, 32'h7);
        apb(1'b1, tifs_pkg::CTRL_OFF, 32'((m << tifs_pkg::CTRL_MODE_LSB) | ((t + 1) & 3)));
        apb(1'b0, tifs_pkg::FRAME_OFF, 32'h0);
        chk("frame_reg", 32'h0, rd);
        hold <= 1'b0;
        n = 0;
        while (ocnt < cur_len && n < 500) begin
            @(posedge pclk);
            n++;
        end
        go   <= 1'b0;
        hold <= 1'b1;
        chk("out_count", 32'(cur_len), 32'(ocnt));
        apb(1'b0, tifs_pkg::LEN_OFF, 32'h0);
        chk("len_kept", 32'(cur_len), rd);
        apb(1'b0, tifs_pkg::STAT_OFF, 32'h0);
        chk("stat", 32'(((b + 1) << 3) | 1), rd);
        apb(1'b0, tifs_pkg::CTRL_OFF, 32'h0);
        chk("ctrl_kept", 32'((m << tifs_pkg::CTRL_MODE_LSB) | t), rd);
    endtask
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        go = 1'b0;
        hold = 1'b1;
        slow = 1'b0;
        nbits = 16'h0000;
        fails = 0;
        total_checks = 0;
        ocnt = 0;
        cur_len = 1;
        cur_tti = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tifs_pkg::CTRL_OFF, 32'h0);
        chk("ctrl_rst", 32'h0, rd);
        apb(1'b0, tifs_pkg::LEN_OFF, 32'h0);
        chk("len_rst", {16'h0000, tifs_pkg::LEN_RST}, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        for (int b = 0; b < 6; b++) run(b, b % 4, b % 3, b[0]);
        results();
    end
endmodule
